// File: rtl/upf_map.svh
// Constants of the function-control register bank: addresses, fields, resets, timing.
// Assumes inclusion by the design modules, checker and bench of this bank only.
// Overview of operation
// - Read-only upper part code byte, writes ignored
// - Function control readable at three alias addresses
// - Set ORs byte in, clear zeroes masked bits
// - Reset value: powered, full speed, rest zero
// - Suspend bit zero enters low-power mode
// - Device restores suspend bit itself on wake
// - Reset bit: DIR high, core reset, registers kept
// - Reset done: DIR low, bit cleared, RXCMD sent
// - Operation style selects transmit encoding behaviour
// - Termination bit steers pull-up and HS terminations
// - Speed field enables one transceiver, none in low power or core reset
// - Speed 11b prefixes full-speed preamble
`ifndef UPF_MAP_SVH
`define UPF_MAP_SVH

`define UPF_ADDR_PART_UPPER 6'h03
`define UPF_ADDR_FC_WRITE 6'h04
`define UPF_ADDR_FC_SET 6'h05
`define UPF_ADDR_FC_CLEAR 6'h06

`define UPF_PART_UPPER_VALUE 8'h5A
`define UPF_FC_RESET 8'h41
`define UPF_FC_USED_MASK 8'h7F
`define UPF_READ_UNMAPPED 8'h00
`define UPF_RXCMD_IDLE 8'h00

`define UPF_FC_SUSP_BIT 6
`define UPF_FC_RST_BIT 5
`define UPF_FC_OP_MSB 4
`define UPF_FC_OP_LSB 3
`define UPF_FC_TERM_BIT 2
`define UPF_FC_SPD_MSB 1
`define UPF_FC_SPD_LSB 0

`define UPF_TXCMD_REG_WRITE 2'h2
`define UPF_TXCMD_REG_READ 2'h3

`define UPF_SYS_CLK_NS 10
`define UPF_CORE_RST_NS 200
`define UPF_CORE_RST_CYC ((`UPF_CORE_RST_NS + `UPF_SYS_CLK_NS - 1) / `UPF_SYS_CLK_NS)
`define UPF_RST_CNT_W 8

`endif

// File: rtl/upf_pkg.sv
// Types shared by the function-control bank modules.
// Assumes nothing beyond a SystemVerilog compiler.
package upf_pkg;

    typedef enum logic [3:0] {
        UPF_LS_IDLE,
        UPF_LS_WR_ACK,
        UPF_LS_WR_DATA,
        UPF_LS_WR_STP,
        UPF_LS_RD_ACK,
        UPF_LS_RD_TURN,
        UPF_LS_RD_DATA,
        UPF_LS_RST_HOLD,
        UPF_LS_RX_GAP,
        UPF_LS_RX_TURN,
        UPF_LS_RX_DATA,
        UPF_LS_SLEEP
    } upf_link_state_t;

    typedef enum logic [1:0] {
        UPF_SPD_HIGH,
        UPF_SPD_FULL,
        UPF_SPD_LOW,
        UPF_SPD_FULL_FOR_LOW
    } upf_speed_t;

    typedef enum logic [1:0] {
        UPF_OP_NORMAL,
        UPF_OP_NON_DRIVING,
        UPF_OP_RAW_BITS,
        UPF_OP_NO_SYNC_EOP
    } upf_op_style_t;

endpackage : upf_pkg

// File: rtl/upf_reset_if.sv
// Carrier between the top module and the core reset sequencer.
// Assumes rstReqToggle lives on the ULPI clock and the rest on sys_clk.
interface upf_reset_if;
    logic rstReqToggle;
    logic rstDoneToggle;
    logic coreRstActive;

    modport top (
        output rstReqToggle,
        input rstDoneToggle,
        input coreRstActive
    );

    modport seq (
        input rstReqToggle,
        output rstDoneToggle,
        output coreRstActive
    );
endinterface : upf_reset_if

// File: rtl/upf_core_reset.sv
// Core reset sequencer on sys_clk: runs one timed core reset per request toggle.
// Assumes the request toggle arrives from the ULPI clock domain.
`include "upf_map.svh"
module upf_core_reset
    import upf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    upf_reset_if.seq rstIf
);

    logic [2:0] reqSync_q;
    logic reqEdge;
    logic running_q;
    logic doneToggle_q;
    logic [`UPF_RST_CNT_W-1:0] count_q;

    ////////////////////////////////////////////////////////////////////////////
    // Request crossing: stage 0 feeds stage 1 only
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reqSync_q <= 3'h0;
        end else begin
            reqSync_q <= {reqSync_q[1:0], rstIf.rstReqToggle};
        end
    end

    assign reqEdge = reqSync_q[2] ^ reqSync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Timed core reset; register contents live elsewhere and are untouched
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            running_q <= 1'b0;
            count_q <= '0;
        end else if (reqEdge && !running_q) begin
            running_q <= 1'b1;
            count_q <= `UPF_RST_CNT_W'(`UPF_CORE_RST_CYC - 1);
        end else if (running_q) begin
            if (count_q == '0) begin
                running_q <= 1'b0;
            end else begin
                count_q <= count_q - `UPF_RST_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            doneToggle_q <= 1'b0;
        end else if (running_q && count_q == '0) begin
            doneToggle_q <= ~doneToggle_q;
        end
    end

    assign rstIf.rstDoneToggle = doneToggle_q;
    assign rstIf.coreRstActive = running_q;

endmodule : upf_core_reset

// File: rtl/upf_function_control.sv
// Function-control register bank of a ULPI transceiver, device side.
// Assumes ULPI pins are synchronous to ulpiClk and the core runs on sys_clk.
`include "upf_map.svh"
module upf_function_control
    import upf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ulpiClk,
    input wire logic ulpiStp,
    input wire logic [7:0] ulpiDataIn,
    output logic [7:0] ulpiDataOut,
    output logic ulpiDataOeN,
    output logic ulpiDir,
    output logic ulpiNxt,
    input wire logic plusLinePulldown,
    input wire logic minusLinePulldown,
    output logic coreResetActive,
    output logic lowPowerMode,
    output logic fsReceiverEnable,
    output logic hsXcvrEnable,
    output logic fsXcvrEnable,
    output logic lsXcvrEnable,
    output logic fsPreambleEnable,
    output logic txNonDriving,
    output logic txRawBits,
    output logic txNoSyncEop,
    output logic plusPullupEnable,
    output logic minusPullupEnable,
    output logic hsTermEnable
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    upf_reset_if rstIf ();
    logic linkRstMeta_q;
    logic linkRst_q;
    logic [2:0] doneSync_q;
    logic coreDone;
    upf_link_state_t state_q;
    logic [5:0] regAddr_q;
    logic [7:0] functionControl_q;
    logic [7:0] functionControl_d;
    logic [7:0] writeResult;
    logic regWriteFire;
    logic wakeEvent;
    logic rstReqToggle_q;
    logic startCoreRst;
    logic dir_q;
    logic nxt_q;
    logic [7:0] dataOut_q;
    logic dataOeN_q;
    logic [7:0] fcMeta_q;
    logic [7:0] fcSync_q;
    logic [7:0] fcLast_q;
    logic [7:0] fcSys_q;
    logic [1:0] pdMeta_q;
    logic [1:0] pdSys_q;
    logic coreActive;
    logic hostPulldowns;
    upf_speed_t speedChoice;
    upf_op_style_t opStyle;
    logic terminationChoice;
    ////////////////////////////////////////////////////////////////////////////
    // Register helpers
    function automatic logic [7:0] readRegister(
        input logic [5:0] addr,
        input logic [7:0] fc
    );
        logic [7:0] value;
        value = `UPF_READ_UNMAPPED;
        if (addr == `UPF_ADDR_PART_UPPER) begin
            value = `UPF_PART_UPPER_VALUE;
        end else if (addr == `UPF_ADDR_FC_WRITE || addr == `UPF_ADDR_FC_SET
                     || addr == `UPF_ADDR_FC_CLEAR) begin
            value = fc;
        end
        return value;
    endfunction : readRegister

    function automatic logic [7:0] applyWrite(
        input logic [5:0] addr,
        input logic [7:0] fc,
        input logic [7:0] data
    );
        logic [7:0] value;
        value = fc;
        if (addr == `UPF_ADDR_FC_WRITE) begin
            value = data;
        end else if (addr == `UPF_ADDR_FC_SET) begin
            value = fc | data;
        end else if (addr == `UPF_ADDR_FC_CLEAR) begin
            value = fc & ~data;
        end
        return value;
    endfunction : applyWrite

    ////////////////////////////////////////////////////////////////////////////
    // Link-domain reset and reset-done crossing
    always_ff @(posedge ulpiClk) begin
        linkRstMeta_q <= sys_rst;
        linkRst_q <= linkRstMeta_q;
    end

    always_ff @(posedge ulpiClk) begin
        if (linkRst_q) begin
            doneSync_q <= 3'h0;
        end else begin
            doneSync_q <= {doneSync_q[1:0], rstIf.rstDoneToggle};
        end
    end

    assign coreDone = doneSync_q[2] ^ doneSync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // ULPI register protocol engine
    assign regWriteFire = (state_q == UPF_LS_WR_DATA);
    assign wakeEvent = (state_q == UPF_LS_SLEEP) && ulpiStp;
    assign startCoreRst = (state_q == UPF_LS_WR_STP) && ulpiStp
                          && functionControl_q[`UPF_FC_RST_BIT];

    always_ff @(posedge ulpiClk) begin
        if (linkRst_q) begin
            state_q <= UPF_LS_IDLE;
            regAddr_q <= 6'h00;
            dir_q <= 1'b0;
            nxt_q <= 1'b0;
            dataOut_q <= 8'h00;
            dataOeN_q <= 1'b1;
        end else begin
            unique case (state_q)
                UPF_LS_IDLE: begin
                    if (ulpiDataIn[7:6] == `UPF_TXCMD_REG_WRITE) begin
                        regAddr_q <= ulpiDataIn[5:0];
                        nxt_q <= 1'b1;
                        state_q <= UPF_LS_WR_ACK;
                    end else if (ulpiDataIn[7:6] == `UPF_TXCMD_REG_READ) begin
                        regAddr_q <= ulpiDataIn[5:0];
                        nxt_q <= 1'b1;
                        state_q <= UPF_LS_RD_ACK;
                    end
                end
                UPF_LS_WR_ACK: begin
                    state_q <= UPF_LS_WR_DATA;
                end
                UPF_LS_WR_DATA: begin
                    nxt_q <= 1'b0;
                    state_q <= UPF_LS_WR_STP;
                end
                UPF_LS_WR_STP: begin
                    if (ulpiStp) begin
                        if (functionControl_q[`UPF_FC_RST_BIT]) begin
                            dir_q <= 1'b1;
                            state_q <= UPF_LS_RST_HOLD;
                        end else if (!functionControl_q[`UPF_FC_SUSP_BIT]) begin
                            dir_q <= 1'b1;
                            state_q <= UPF_LS_SLEEP;
                        end else begin
                            state_q <= UPF_LS_IDLE;
                        end
                    end
                end
                UPF_LS_RD_ACK: begin
                    nxt_q <= 1'b0;
                    dir_q <= 1'b1;
                    state_q <= UPF_LS_RD_TURN;
                end
                UPF_LS_RD_TURN: begin
                    dataOut_q <= readRegister(regAddr_q, functionControl_q);
                    dataOeN_q <= 1'b0;
                    state_q <= UPF_LS_RD_DATA;
                end
                UPF_LS_RD_DATA: begin
                    dir_q <= 1'b0;
                    dataOeN_q <= 1'b1;
                    state_q <= UPF_LS_IDLE;
                end
                UPF_LS_RST_HOLD: begin
                    if (coreDone) begin
                        dir_q <= 1'b0;
                        state_q <= UPF_LS_RX_GAP;
                    end
                end
                UPF_LS_RX_GAP: begin
                    dir_q <= 1'b1;
                    state_q <= UPF_LS_RX_TURN;
                end
                UPF_LS_RX_TURN: begin
                    dataOut_q <= `UPF_RXCMD_IDLE;
                    dataOeN_q <= 1'b0;
                    state_q <= UPF_LS_RX_DATA;
                end
                UPF_LS_RX_DATA: begin
                    dir_q <= 1'b0;
                    dataOeN_q <= 1'b1;
                    state_q <= UPF_LS_IDLE;
                end
                UPF_LS_SLEEP: begin
                    if (ulpiStp) begin
                        dir_q <= 1'b0;
                        state_q <= UPF_LS_IDLE;
                    end
                end
                default: begin
                    state_q <= UPF_LS_IDLE;
                end
            endcase
        end
    end

    assign ulpiDir = dir_q;
    assign ulpiNxt = nxt_q;
    assign ulpiDataOut = dataOut_q;
    assign ulpiDataOeN = dataOeN_q;

    ////////////////////////////////////////////////////////////////////////////
    // Function control register; the sequencer clears only its reset bit, the core reset keeps it
    assign writeResult = applyWrite(regAddr_q, functionControl_q, ulpiDataIn);

    always_comb begin
        functionControl_d = functionControl_q;
        if (regWriteFire) begin
            functionControl_d = writeResult;
        end
        if (coreDone) begin
            functionControl_d[`UPF_FC_RST_BIT] = 1'b0;
        end
        if (wakeEvent) begin
            functionControl_d[`UPF_FC_SUSP_BIT] = 1'b1;
        end
    end

    always_ff @(posedge ulpiClk) begin
        if (linkRst_q) begin
            functionControl_q <= `UPF_FC_RESET;
        end else begin
            functionControl_q <= functionControl_d;
        end
    end

    always_ff @(posedge ulpiClk) begin
        if (linkRst_q) begin
            rstReqToggle_q <= 1'b0;
        end else if (startCoreRst) begin
            rstReqToggle_q <= ~rstReqToggle_q;
        end
    end

    assign rstIf.rstReqToggle = rstReqToggle_q;

    upf_core_reset coreReset (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rstIf(rstIf.seq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into sys_clk; a word is taken only after two equal samples
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fcMeta_q <= `UPF_FC_RESET;
            fcSync_q <= `UPF_FC_RESET;
            fcLast_q <= `UPF_FC_RESET;
            fcSys_q <= `UPF_FC_RESET;
            pdMeta_q <= 2'h0;
            pdSys_q <= 2'h0;
        end else begin
            fcMeta_q <= functionControl_q;
            fcSync_q <= fcMeta_q;
            fcLast_q <= fcSync_q;
            fcSys_q <= (fcSync_q == fcLast_q) ? fcSync_q : fcSys_q;
            pdMeta_q <= {plusLinePulldown, minusLinePulldown};
            pdSys_q <= pdMeta_q;
        end
    end

    assign speedChoice = upf_speed_t'(fcSys_q[`UPF_FC_SPD_MSB:`UPF_FC_SPD_LSB]);
    assign opStyle = upf_op_style_t'(fcSys_q[`UPF_FC_OP_MSB:`UPF_FC_OP_LSB]);
    assign terminationChoice = fcSys_q[`UPF_FC_TERM_BIT];
    assign hostPulldowns = pdSys_q[1] && pdSys_q[0];
    assign coreActive = fcSys_q[`UPF_FC_SUSP_BIT] && !rstIf.coreRstActive;

    ////////////////////////////////////////////////////////////////////////////
    // Power and transceiver selection
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            coreResetActive <= 1'b0;
            lowPowerMode <= 1'b0;
            fsReceiverEnable <= 1'b0;
            hsXcvrEnable <= 1'b0;
            fsXcvrEnable <= 1'b0;
            lsXcvrEnable <= 1'b0;
            fsPreambleEnable <= 1'b0;
        end else begin
            coreResetActive <= rstIf.coreRstActive;
            lowPowerMode <= !fcSys_q[`UPF_FC_SUSP_BIT];
            fsReceiverEnable <= !rstIf.coreRstActive;
            hsXcvrEnable <= coreActive && speedChoice == UPF_SPD_HIGH;
            fsXcvrEnable <= coreActive && (speedChoice == UPF_SPD_FULL
                            || speedChoice == UPF_SPD_FULL_FOR_LOW);
            lsXcvrEnable <= coreActive && speedChoice == UPF_SPD_LOW;
            fsPreambleEnable <= coreActive
                                && speedChoice == UPF_SPD_FULL_FOR_LOW;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit encoding style
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            txNonDriving <= 1'b0;
            txRawBits <= 1'b0;
            txNoSyncEop <= 1'b0;
        end else begin
            txNonDriving <= coreActive && opStyle == UPF_OP_NON_DRIVING;
            txRawBits <= coreActive && opStyle == UPF_OP_RAW_BITS;
            txNoSyncEop <= coreActive && opStyle == UPF_OP_NO_SYNC_EOP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus terminations: a host (both pull-downs) never enables a pull-up
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            plusPullupEnable <= 1'b0;
            minusPullupEnable <= 1'b0;
            hsTermEnable <= 1'b0;
        end else begin
            plusPullupEnable <= coreActive && !hostPulldowns && terminationChoice
                                && speedChoice != UPF_SPD_LOW;
            minusPullupEnable <= coreActive && !hostPulldowns && terminationChoice
                                 && speedChoice == UPF_SPD_LOW;
            hsTermEnable <= coreActive && !terminationChoice
                            && speedChoice == UPF_SPD_HIGH
                            && opStyle != UPF_OP_NON_DRIVING;
        end
    end

endmodule : upf_function_control

// File: tb/upf_function_control_chk.sv
// Port checker of the function-control bank.
// Assumes the ULPI register handshake timing of the bank's link engine.
`include "upf_map.svh"
module upf_function_control_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ulpiClk,
    input wire logic [7:0] ulpiDataIn,
    input wire logic [7:0] ulpiDataOut,
    input wire logic ulpiDataOeN,
    input wire logic ulpiDir,
    input wire logic ulpiNxt,
    input wire logic coreResetActive,
    input wire logic lowPowerMode,
    input wire logic fsReceiverEnable,
    input wire logic hsXcvrEnable,
    input wire logic fsXcvrEnable,
    input wire logic lsXcvrEnable,
    input wire logic plusPullupEnable,
    input wire logic minusPullupEnable,
    input wire logic hsTermEnable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rstCnt_q;
    logic rstSeen_q;
    // Length of the running core reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !coreResetActive) rstCnt_q <= 8'h00;
        else rstCnt_q <= rstCnt_q + 8'h01;
    end
    // Marks a DIR period that belongs to a core reset
    always_ff @(posedge ulpiClk) begin
        if (sys_rst) rstSeen_q <= 1'b0;
        else if (coreResetActive) rstSeen_q <= 1'b1;
        else if (!ulpiDir) rstSeen_q <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence wrAckSeq;
        ulpiNxt ##1 !ulpiNxt;
    endsequence
    sequence rdTurnSeq;
        (ulpiDir && !ulpiNxt) ##1 !ulpiDataOeN ##1 (!ulpiDir && ulpiDataOeN);
    endsequence
    sequence rxCmdSeq;
        ulpiDir ##1 (!ulpiDataOeN && ulpiDataOut == `UPF_RXCMD_IDLE) ##1 !ulpiDir;
    endsequence
    chk_write_ack: assert property (@(posedge ulpiClk) disable iff (sys_rst)
        $rose(ulpiNxt) && $past(ulpiDataIn[7:6]) == 2'h2 |=> wrAckSeq)
        else $error("write acknowledge timing wrong");
    chk_read_turn: assert property (@(posedge ulpiClk) disable iff (sys_rst)
        $rose(ulpiNxt) && $past(ulpiDataIn[7:6]) == 2'h3 |=> rdTurnSeq)
        else $error("read turnaround timing wrong");
    chk_part_code: assert property (@(posedge ulpiClk) disable iff (sys_rst)
        $rose(ulpiNxt) && $past(ulpiDataIn) == 8'hC3 |-> ##2
        ulpiDataOut == `UPF_PART_UPPER_VALUE)
        else $error("part code byte wrong");
    chk_drive_dir: assert property (@(posedge ulpiClk) disable iff (sys_rst)
        !ulpiDataOeN |-> ulpiDir && $past(ulpiDir))
        else $error("data driven without a settled DIR");
    chk_rst_dir: assert property (@(posedge ulpiClk) disable iff (sys_rst)
        coreResetActive |-> ulpiDir)
        else $error("DIR low during core reset");
    chk_rst_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(coreResetActive) |-> rstCnt_q >= `UPF_CORE_RST_CYC
        && rstCnt_q <= `UPF_CORE_RST_CYC + 1)
        else $error("core reset length wrong");
    chk_rxcmd_after: assert property (@(posedge ulpiClk) disable iff (sys_rst)
        $fell(ulpiDir) && rstSeen_q |=> rxCmdSeq)
        else $error("no status update after core reset");
    chk_sleep_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
        lowPowerMode && $past(lowPowerMode) |->
        fsReceiverEnable && !(hsXcvrEnable || fsXcvrEnable || lsXcvrEnable))
        else $error("low-power gating wrong");
    chk_one_xcvr: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $onehot0({hsXcvrEnable, fsXcvrEnable, lsXcvrEnable}))
        else $error("more than one transceiver enabled");
    chk_term_excl: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hsTermEnable |-> !plusPullupEnable && !minusPullupEnable)
        else $error("pull-up and HS termination together");
endmodule : upf_function_control_chk

bind upf_function_control upf_function_control_chk chk (.sys_clk, .sys_rst, .ulpiClk,
    .ulpiDataIn, .ulpiDataOut, .ulpiDataOeN, .ulpiDir, .ulpiNxt, .coreResetActive,
    .lowPowerMode, .fsReceiverEnable, .hsXcvrEnable, .fsXcvrEnable, .lsXcvrEnable,
    .plusPullupEnable, .minusPullupEnable, .hsTermEnable);

// File: tb/upf_link_model.sv
// Link controller model: ULPI register writes, reads and wake-up.
// Assumes the bench resolves the data bus from DIR and the device drive enable.
module upf_link_model (
    input wire logic ulpiClk,
    input wire logic ulpiDir,
    input wire logic ulpiNxt,
    output logic ulpiStp,
    output logic [7:0] linkData
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ulpiStp = 1'b0;
        linkData = 8'h00;
    end
    task automatic reg_write(input logic [5:0] addr, input logic [7:0] data);
        while (ulpiDir !== 1'b0) @(posedge ulpiClk);
        @(posedge ulpiClk);
        #1 linkData = {2'h2, addr};
        do @(posedge ulpiClk); while (ulpiNxt !== 1'b1);
        #1 linkData = data;
        @(posedge ulpiClk);
        #1 linkData = 8'h00;
        ulpiStp = 1'b1;
        @(posedge ulpiClk);
        #1 ulpiStp = 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [5:0] addr);
        while (ulpiDir !== 1'b0) @(posedge ulpiClk);
        @(posedge ulpiClk);
        #1 linkData = {2'h3, addr};
        do @(posedge ulpiClk); while (ulpiNxt !== 1'b1);
        #1 linkData = 8'h00;
        repeat (3) @(posedge ulpiClk);
    endtask : reg_read
    task automatic wake();
        @(posedge ulpiClk);
        #1 ulpiStp = 1'b1;
        do @(posedge ulpiClk); while (ulpiDir !== 1'b0);
        #1 ulpiStp = 1'b0;
    endtask : wake
endmodule : upf_link_model

// File: tb/upf_function_control_tb.sv
// Self-checking bench of the function-control bank.
// Assumes the design files, the checker and the link model are compiled first.
`include "upf_map.svh"
module upf_function_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, sys_rst, ulpiClk, ulpiStp, ulpiDataOeN, ulpiDir, ulpiNxt;
    logic plusLinePulldown, minusLinePulldown, coreResetActive, lowPowerMode;
    logic fsReceiverEnable, hsXcvrEnable, fsXcvrEnable, lsXcvrEnable, fsPreambleEnable;
    logic txNonDriving, txRawBits, txNoSyncEop, plusPullupEnable, minusPullupEnable;
    logic hsTermEnable;
    logic [7:0] ulpiDataIn, ulpiDataOut, linkData, v, expV;
    logic [7:0] floatPat = 8'h00;
    logic [7:0] expQ[$];
    logic [31:0] r;
    integer seed = 10;
    int mismatches = 0;
    int nCompared = 0;
    int cycles = 0;
    int k;
    // Undriven bus shows a changing pattern
    assign ulpiDataIn = !ulpiDataOeN ? ulpiDataOut : (!ulpiDir ? linkData : floatPat);
    upf_function_control dut (.*);
    upf_link_model link (.ulpiClk, .ulpiDir, .ulpiNxt, .ulpiStp, .linkData);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        ulpiClk = 1'b0;
        #7;
        forever #24 ulpiClk = ~ulpiClk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic completeRun();
        if (mismatches == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : completeRun
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        nCompared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        expQ.push_back(e);
        link.reg_read(a);
    endtask : rd
    task automatic decode(input logic [7:0] fc);
        logic [1:0] spd;
        logic [1:0] op;
        logic pull;
        spd = fc[1:0];
        op = fc[4:3];
        pull = fc[2] && !(plusLinePulldown && minusLinePulldown);
        repeat (6) @(posedge sys_clk);
        #1 check("decode", {hsXcvrEnable, fsXcvrEnable, lsXcvrEnable, fsPreambleEnable,
            txNonDriving, txRawBits, txNoSyncEop, plusPullupEnable, minusPullupEnable,
            hsTermEnable}, {spd == 2'h0, spd[0], spd == 2'h2, spd == 2'h3, op == 2'h1,
            op == 2'h2, op == 2'h3, pull && spd != 2'h2, pull && spd == 2'h2,
            spd == 2'h0 && !fc[2] && op != 2'h1});
    endtask : decode
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge ulpiClk) begin
        floatPat <= floatPat + 8'h35;
        if (!sys_rst && ulpiDataOeN === 1'b0) begin
            expV = (expQ.size() > 0) ? expQ.pop_front() : 8'hxx;
            check("ulpiData", {2'h0, ulpiDataOut}, {2'h0, expV});
        end
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            completeRun();
        end
    end
    initial begin
        sys_rst = 1'b1;
        plusLinePulldown = 1'b0;
        minusLinePulldown = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        repeat (8) @(posedge ulpiClk);
        decode(8'h41);
        for (k = 3; k < 7; k++) rd(6'(k), k == 3 ? `UPF_PART_UPPER_VALUE : 8'h41);
        link.reg_write(6'h03, 8'hA5);
        rd(6'h03, `UPF_PART_UPPER_VALUE);
        rd(6'h2A, 8'h00);
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            @(posedge ulpiClk);
            #1 plusLinePulldown = r[8];
            minusLinePulldown = r[9];
            v = {r[7], 2'h2, 2'(i >> 2), r[0], (i >> 2) == 3 ? 2'h0 : 2'(i)};
            link.reg_write(6'h04, v);
            rd(6'(4 + i % 3), v);
            decode(v);
        end
        link.reg_write(6'h04, 8'h41);
        link.reg_write(6'h05, 8'h84);
        rd(6'h04, 8'hC5);
        link.reg_write(6'h06, 8'h81);
        rd(6'h05, 8'h44);
        link.reg_write(6'h06, 8'h40);
        repeat (10) @(posedge sys_clk);
        #1 check("sleep", {lowPowerMode, fsReceiverEnable, hsXcvrEnable, fsXcvrEnable,
            lsXcvrEnable, 5'h00}, 10'h300);
        link.wake();
        rd(6'h04, 8'h44);
        expQ.push_back(8'h00);
        link.reg_write(6'h05, 8'h20);
        for (k = 0; k < 200 && coreResetActive !== 1'b1; k++) @(posedge sys_clk);
        #1 check("coreReset", {8'h00, coreResetActive, fsReceiverEnable}, 10'h002);
        for (k = 0; k < 200 && coreResetActive !== 1'b0; k++) @(posedge sys_clk);
        repeat (8) @(posedge ulpiClk);
        rd(6'h06, 8'h44);
        decode(8'h44);
        check("pending", 10'(expQ.size()), 10'h000);
        completeRun();
    end
endmodule : upf_function_control_tb
